// file: fxa_pkg.sv
// constants and types for the flash and external RAM access control block
// assumes the core clock plus the one-shot oscillator clk_os_i, and a synchronous reset
// Functional notes
// - erase enable plus write enable erases page
// - write enable turns moves into byte programs
// - control upper six bits read zero
// - reset timing valid up to 25 MHz
// - read strobe one or two clocks
// - flash array active only during strobe
// - mid-range clocks use clock-period strobe width
// - slow clocks end strobe by one-shot
// - page erase takes about 20 ms
// - byte write takes about 46 us
// - top 512 flash bytes are reserved
// - 2048 bytes of external RAM
// - 8-bit moves take high byte from page
// - 16-bit RAM moves ignore top five address bits
// - move writes reach RAM unless write enabled; move reads always return RAM data
// - unsafe supply monitor during a write-enabled move causes flash-error reset
package fxa_pkg;
	localparam logic [7:0] PSC_ADDR       = 8'h8f;
	localparam logic [7:0] XPG_ADDR       = 8'haa;
	localparam logic [7:0] FRS_ADDR       = 8'hb6;
	localparam logic [7:0] PSC_RESET      = 8'h00;
	localparam logic [7:0] XPG_RESET      = 8'h00;
	localparam logic [7:0] FRS_RESET      = 8'h00;
	localparam int         PSC_WE_BIT     = 0;
	localparam int         PSC_EE_BIT     = 1;
	localparam int         FRS_RT_BIT     = 4;
	localparam int         XRAM_BYTES     = 2048;
	localparam int         XRAM_AW        = 11;
	localparam int         FLASH_AW       = 15;
	localparam int         PAGE_AW        = 9;
	localparam logic [15:0] RSVD_LO       = 16'h7e00;
	localparam logic [15:0] RSVD_HI       = 16'h7fff;
	localparam int         CLK_NS         = 40;
	localparam int         ERASE_MS       = 20;
	localparam int         WRITE_US       = 46;
	localparam int         ERASE_CYC      = ERASE_MS * 1000000 / CLK_NS;
	localparam int         WRITE_CYC      = WRITE_US * 1000 / CLK_NS;
	localparam int         ONESHOT_NS     = 80;
	localparam int         OS_STEP_NS     = 5;
	localparam logic [3:0] OS_RESET       =
		4'((ONESHOT_NS + OS_STEP_NS - 1) / OS_STEP_NS - 1);
	typedef enum logic [1:0] {
		FXA_IDLE,
		FXA_WRITE,
		FXA_ERASE
	} fxa_op_t;
endpackage : fxa_pkg

// file: fxa_oneshot.sv
// one-shot timer ending the flash read strobe at slow core clocks
// assumes a free-running fast oscillator clk_os_i of OS_STEP_NS period
`timescale 1ns/1ns
module fxa_oneshot (
	input  wire logic       clk_os_i,
	input  wire logic       reset_i,
	input  wire logic       fire_i,
	input  wire logic [3:0] period_i,
	output logic            active_o
);
	logic [3:0] cnt_q;
	logic       run_q;
	logic       fire_q;
	// start on the rising edge only: a long request must not retrigger
	wire        fire_edge = fire_i && !fire_q;
	always_ff @(posedge clk_os_i) begin
		if (reset_i)
			fire_q <= 1'b0;
		else
			fire_q <= fire_i;
	end
	// counts in its own clock so that slow core clocks still get a short strobe
	always_ff @(posedge clk_os_i) begin
		if (reset_i) begin
			cnt_q <= 4'h0;
			run_q <= 1'b0;
		end else if (fire_edge && !run_q) begin
			cnt_q <= period_i;
			run_q <= 1'b1;
		end else if (run_q) begin
			if (cnt_q == 4'h0)
				run_q <= 1'b0;
			cnt_q <= cnt_q - 4'h1;
		end
	end
	assign active_o = run_q;
endmodule : fxa_oneshot

// file: fxa_xram.sv
// 2 kB external data RAM, one synchronous read/write port
// assumes byte address already folded to eleven bits
`timescale 1ns/1ns
module fxa_xram (
	input  wire logic        mclk_i,
	input  wire logic        we_i,
	input  wire logic [10:0] addr_i,
	input  wire logic [7:0]  wdata_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] mem [fxa_pkg::XRAM_BYTES];
	always_ff @(posedge mclk_i) begin
		if (we_i)
			mem[addr_i] <= wdata_i;
		rdata_o <= mem[addr_i];
	end
endmodule : fxa_xram

// file: fxa_top.sv
// program store control, flash read timing and external RAM mapping
// assumes the core drives one register access or one move per cycle
`timescale 1ns/1ns
module fxa_top #(
	parameter int ERASE_CYCLES = fxa_pkg::ERASE_CYC,
	parameter int WRITE_CYCLES = fxa_pkg::WRITE_CYC
) (
	input  wire logic        mclk_i,
	input  wire logic        reset_i,
	input  wire logic        clk_os_i,
	input  wire logic        slow_clock_i,
	input  wire logic        mon_safe_i,
	input  wire logic        reg_wr_i,
	input  wire logic        reg_rd_i,
	input  wire logic [7:0]  reg_addr_i,
	input  wire logic [7:0]  reg_wdata_i,
	output logic      [7:0]  reg_rdata_o,
	input  wire logic        os_period_wr_i,
	input  wire logic [3:0]  os_period_i,
	input  wire logic        move_wr_i,
	input  wire logic        move_rd_i,
	input  wire logic        move_short_i,
	input  wire logic [15:0] move_addr_i,
	input  wire logic [7:0]  move_wdata_i,
	output logic      [7:0]  move_rdata_o,
	input  wire logic        fetch_i,
	output logic             read_strobe_o,
	output logic             flash_active_o,
	output logic             flash_prog_o,
	output logic             flash_erase_o,
	output logic      [14:0] flash_addr_o,
	output logic      [7:0]  flash_wdata_o,
	output logic             flash_busy_o,
	output logic             core_stall_o,
	output logic             reserved_hit_o,
	output logic             flash_err_reset_o
);
	logic [1:0]  psc_q;
	logic [7:0]  xpg_q;
	logic        rt_q;
	logic [3:0]  os_q;
	logic [24:0] tmr_q;
	logic [24:0] tmr_d;
	fxa_pkg::fxa_op_t op_q;
	fxa_pkg::fxa_op_t op_d;
	logic [1:0]  strobe_cnt_q;
	logic [7:0]  rdata_q;
	logic        err_q;
	logic [14:0] faddr_q;
	logic [7:0]  fdata_q;
	logic        rdsel_q;

	wire hit_psc = reg_addr_i == fxa_pkg::PSC_ADDR;
	wire hit_xpg = reg_addr_i == fxa_pkg::XPG_ADDR;
	wire hit_frs = reg_addr_i == fxa_pkg::FRS_ADDR;
	wire we_en   = psc_q[fxa_pkg::PSC_WE_BIT];
	wire ee_en   = psc_q[fxa_pkg::PSC_EE_BIT];
	wire busy    = op_q != fxa_pkg::FXA_IDLE;

	// 8-bit moves borrow the page register as high byte
	wire [15:0] eff_addr = move_short_i ? {xpg_q, move_addr_i[7:0]}
		: move_addr_i;
	// top five bits dropped so the RAM repeats every 2 kB
	wire [10:0] ram_addr = eff_addr[fxa_pkg::XRAM_AW-1:0];
	wire flash_move = move_wr_i && we_en && !busy;
	wire ram_we     = move_wr_i && !we_en;
	wire flash_ok   = flash_move && mon_safe_i;
	wire in_rsvd    = eff_addr >= fxa_pkg::RSVD_LO
		&& eff_addr <= fxa_pkg::RSVD_HI;
	wire rd_req     = (fetch_i || (move_rd_i && we_en)) && !busy;

	logic [7:0] ram_rdata;
	fxa_xram u_xram (
		.mclk_i  (mclk_i),
		.we_i    (ram_we),
		.addr_i  (ram_addr),
		.wdata_i (move_wdata_i),
		.rdata_o (ram_rdata)
	);

	logic os_active;
	fxa_oneshot u_os (
		.clk_os_i (clk_os_i),
		.reset_i  (reset_i),
		.fire_i   (rd_req),
		.period_i (os_q),
		.active_o (os_active)
	);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			psc_q <= fxa_pkg::PSC_RESET[1:0];
			xpg_q <= fxa_pkg::XPG_RESET;
			rt_q  <= fxa_pkg::FRS_RESET[fxa_pkg::FRS_RT_BIT];
		end else if (reg_wr_i) begin
			if (hit_psc)
				psc_q <= reg_wdata_i[1:0];
			if (hit_xpg)
				xpg_q <= reg_wdata_i;
			if (hit_frs)
				rt_q <= reg_wdata_i[fxa_pkg::FRS_RT_BIT];
		end
	end

	// period trim kept separate: its register layout is not mapped here
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			os_q <= fxa_pkg::OS_RESET;
		else if (os_period_wr_i)
			os_q <= os_period_i;
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			rdata_q <= 8'h00;
		else if (reg_rd_i)
			rdata_q <= hit_psc ? {6'h00, psc_q}
				: hit_xpg ? xpg_q
				: hit_frs ? {3'h0, rt_q, 4'h0}
				: 8'h00;
	end
	assign reg_rdata_o = rdata_q;

	// strobe lasts one clock, or two with the two-cycle bit set
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			strobe_cnt_q <= 2'h0;
		else if (rd_req)
			strobe_cnt_q <= rt_q ? 2'h2 : 2'h1;
		else if (strobe_cnt_q != 2'h0)
			strobe_cnt_q <= strobe_cnt_q - 2'h1;
	end
	wire strobe_win = strobe_cnt_q != 2'h0;
	// slow clocks: one-shot cuts the strobe short to save power
	assign read_strobe_o  = slow_clock_i ? (strobe_win && os_active)
		: strobe_win;
	assign flash_active_o = read_strobe_o;

	always_comb begin
		op_d  = op_q;
		tmr_d = tmr_q;
		case (op_q)
		fxa_pkg::FXA_IDLE: begin
			if (flash_ok && !in_rsvd) begin
				op_d  = ee_en ? fxa_pkg::FXA_ERASE
					: fxa_pkg::FXA_WRITE;
				tmr_d = ee_en ? 25'(ERASE_CYCLES - 1)
					: 25'(WRITE_CYCLES - 1);
			end
		end
		fxa_pkg::FXA_WRITE,
		fxa_pkg::FXA_ERASE: begin
			if (tmr_q == 25'h0)
				op_d = fxa_pkg::FXA_IDLE;
			else
				tmr_d = tmr_q - 25'h1;
		end
		default: op_d = fxa_pkg::FXA_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			op_q  <= fxa_pkg::FXA_IDLE;
			tmr_q <= 25'h0;
		end else begin
			op_q  <= op_d;
			tmr_q <= tmr_d;
		end
	end

	// erase ignores data and clears page-aligned address
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			faddr_q <= 15'h0;
			fdata_q <= 8'h00;
		end else if (op_q == fxa_pkg::FXA_IDLE && flash_ok) begin
			faddr_q <= ee_en
				? {eff_addr[14:fxa_pkg::PAGE_AW], 9'h000}
				: eff_addr[14:0];
			fdata_q <= ee_en ? 8'h00 : move_wdata_i;
		end
	end
	assign flash_addr_o  = faddr_q;
	assign flash_wdata_o = fdata_q;
	assign flash_prog_o  = op_q == fxa_pkg::FXA_WRITE;
	assign flash_erase_o = op_q == fxa_pkg::FXA_ERASE;
	assign flash_busy_o  = busy;
	assign core_stall_o  = busy;

	// unsafe supply monitor or reserved region: reset instead of modify
	always_ff @(posedge mclk_i) begin
		if (reset_i)
			err_q <= 1'b0;
		else
			err_q <= flash_move && (!mon_safe_i || in_rsvd);
	end
	assign flash_err_reset_o = err_q;

	always_ff @(posedge mclk_i) begin
		if (reset_i)
			rdsel_q <= 1'b0;
		else
			rdsel_q <= move_rd_i;
	end
	assign move_rdata_o   = rdsel_q ? ram_rdata : 8'h00;
	assign reserved_hit_o = flash_move && in_rsvd;
endmodule : fxa_top

// file: fxa_monitor.sv
// port assertions for the flash and external RAM access block
// assumes a bind into fxa_top, one core clock
`timescale 1ns/1ns
module fxa_monitor #(
	parameter int WRITE_CYCLES = 5
) (
	input wire logic       mclk_i,
	input wire logic       reset_i,
	input wire logic       fetch_i,
	input wire logic       move_rd_i,
	input wire logic       move_wr_i,
	input wire logic       mon_safe_i,
	input wire logic       reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic       read_strobe_o,
	input wire logic       flash_active_o,
	input wire logic       flash_prog_o,
	input wire logic       flash_erase_o,
	input wire logic       flash_busy_o,
	input wire logic       core_stall_o,
	input wire logic       reserved_hit_o,
	input wire logic       flash_err_reset_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	logic [7:0] pc_q;
	always_ff @(posedge mclk_i)
		pc_q <= flash_prog_o ? pc_q + 8'h01 : 8'h00;
	sequence s_erase_run;
		flash_erase_o[*8];
	endsequence
	a_active_strobe: assert property (flash_active_o == read_strobe_o)
		else $error("flash active outside strobe");
	a_stall_busy: assert property (core_stall_o == flash_busy_o)
		else $error("stall differs from busy");
	a_prog_start: assert property ($rose(flash_prog_o) |->
		$past(move_wr_i) && $past(mon_safe_i))
		else $error("byte write without safe move");
	a_prog_len: assert property ($fell(flash_prog_o) |->
		pc_q == WRITE_CYCLES)
		else $error("byte write length wrong");
	a_erase_len: assert property ($rose(flash_erase_o) |-> s_erase_run)
		else $error("page erase ended early");
	a_err_cause: assert property (flash_err_reset_o |->
		$past(move_wr_i) && (!$past(mon_safe_i) || $past(reserved_hit_o)))
		else $error("error reset without cause");
	a_strobe_src: assert property ($rose(read_strobe_o) |->
		$past(fetch_i) || $past(move_rd_i))
		else $error("strobe without fetch");
	a_strobe_len: assert property ($rose(read_strobe_o) |-> ##2
		!read_strobe_o)
		else $error("strobe longer than two clocks");
	a_ctl_zero: assert property (reg_rd_i && reg_addr_i == 8'h8f |=>
		reg_rdata_o[7:2] == 6'h00)
		else $error("control upper bits not zero");
endmodule : fxa_monitor
bind fxa_top fxa_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (.*);

// file: fxa_core_model.sv
// core model issuing register accesses, moves and fetches
// assumes requests are taken on the rising clock edge
`timescale 1ns/1ns
module fxa_core_model (
	input  wire logic        mclk_i,
	input  wire logic [7:0]  reg_rdata_i,
	input  wire logic [7:0]  move_rdata_i,
	output logic             reg_wr_o,
	output logic             reg_rd_o,
	output logic      [7:0]  reg_addr_o,
	output logic      [7:0]  reg_wdata_o,
	output logic             move_wr_o,
	output logic             move_rd_o,
	output logic             move_short_o,
	output logic      [15:0] move_addr_o,
	output logic      [7:0]  move_wdata_o,
	output logic             fetch_o
);
	initial begin
		{reg_wr_o, reg_rd_o, move_wr_o, move_rd_o, fetch_o} = 5'h00;
		{reg_addr_o, reg_wdata_o, move_wdata_o} = 24'h000000;
		move_short_o = 1'b0;
		move_addr_o = 16'h0000;
	end
	// timing only rewritten at 25 MHz, one-shot period set to zero once by the bench
	task automatic reg_io(input logic w, input logic [7:0] a, d,
		output logic [7:0] q);
		@(negedge mclk_i);
		reg_wr_o = w;
		reg_rd_o = !w;
		reg_addr_o = a;
		reg_wdata_o = d;
		@(negedge mclk_i);
		reg_wr_o = 1'b0;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		q = reg_rdata_i;
	endtask : reg_io
	task automatic move(input logic w, s, input logic [15:0] a,
		input logic [7:0] d, output logic [7:0] q);
		@(negedge mclk_i);
		move_wr_o = w;
		move_rd_o = !w;
		move_short_o = s;
		move_addr_o = a;
		move_wdata_o = d;
		@(negedge mclk_i);
		move_wr_o = 1'b0;
		move_rd_o = 1'b0;
		move_addr_o = ~a;
		q = move_rdata_i;
	endtask : move
	task automatic fetch;
		@(negedge mclk_i);
		fetch_o = 1'b1;
		@(negedge mclk_i);
		fetch_o = 1'b0;
	endtask : fetch
endmodule : fxa_core_model

// file: tb.sv
// self-checking bench for the flash and external RAM access block
// assumes the core model drives every request input except os_period_wr_i, which the bench drives
`timescale 1ns/1ns
module tb;
	logic        mclk_i = 1'b0, reset_i = 1'b1, clk_os_i = 1'b0;
	logic        slow_clock_i = 1'b0, mon_safe_i = 1'b1;
	logic        os_period_wr_i = 1'b0;
	logic [3:0]  os_period_i = 4'hf;
	logic        reg_wr_i, reg_rd_i, move_wr_i, move_rd_i, move_short_i;
	logic        fetch_i, read_strobe_o, flash_active_o, flash_prog_o;
	logic        flash_erase_o, flash_busy_o, core_stall_o, reserved_hit_o;
	logic        flash_err_reset_o;
	logic [7:0]  reg_addr_i, reg_wdata_i, reg_rdata_o, q;
	logic [7:0]  move_wdata_i, move_rdata_o, flash_wdata_o;
	logic [15:0] move_addr_i;
	logic [14:0] flash_addr_o;
	int          errors = 0, total_checks = 0;
	int          busy_n = 0, st_n = 0, err_n = 0, hit_n = 0;
	always #20 mclk_i = ~mclk_i;
	always #3 clk_os_i = ~clk_os_i;
	always @(negedge mclk_i) begin
		busy_n <= busy_n + int'(flash_busy_o);
		st_n <= st_n + int'(read_strobe_o);
		err_n <= err_n + int'(flash_err_reset_o);
	end
	// combinational output: sample on the edge the design takes it
	always @(posedge mclk_i)
		hit_n <= hit_n + int'(reserved_hit_o);
	fxa_top #(.ERASE_CYCLES(20), .WRITE_CYCLES(5)) DUT (.*);
	fxa_core_model CORE (.mclk_i(mclk_i), .reg_rdata_i(reg_rdata_o),
		.move_rdata_i(move_rdata_o), .reg_wr_o(reg_wr_i),
		.reg_rd_o(reg_rd_i), .reg_addr_o(reg_addr_i),
		.reg_wdata_o(reg_wdata_i), .move_wr_o(move_wr_i),
		.move_rd_o(move_rd_i), .move_short_o(move_short_i),
		.move_addr_o(move_addr_i), .move_wdata_o(move_wdata_i),
		.fetch_o(fetch_i));
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask : chk
	task automatic rd_chk(input logic [7:0] a, exp);
		CORE.reg_io(1'b0, a, 8'h00, q);
		chk(16'(q), 16'(exp));
	endtask : rd_chk
	task automatic wait_idle;
		for (int i = 0; i < 60; i++) begin
			@(negedge mclk_i);
			if (flash_busy_o === 1'b0)
				return;
		end
		errors++;
		$display("wrong value at %0t: flash stays busy", $time);
		close_out();
	endtask : wait_idle
	task automatic t_regs;
		rd_chk(fxa_pkg::PSC_ADDR, 8'h00);
		rd_chk(fxa_pkg::FRS_ADDR, 8'h00);
		rd_chk(fxa_pkg::XPG_ADDR, 8'h00);
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, 8'hfc, q);
		rd_chk(fxa_pkg::PSC_ADDR, 8'h00);
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, 8'hff, q);
		rd_chk(fxa_pkg::PSC_ADDR, 8'h03);
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, 8'h00, q);
		$display("register test done");
	endtask : t_regs
	task automatic t_ram;
		int b0;
		b0 = busy_n;
		CORE.move(1'b1, 1'b0, 16'hf805, 8'h5a, q);
		CORE.move(1'b0, 1'b0, 16'h0005, 8'h00, q);
		chk(16'(q), 16'h005a);
		CORE.reg_io(1'b1, fxa_pkg::XPG_ADDR, 8'h03, q);
		rd_chk(fxa_pkg::XPG_ADDR, 8'h03);
		CORE.move(1'b1, 1'b1, 16'hff12, 8'h3c, q);
		CORE.move(1'b0, 1'b0, 16'h0312, 8'h00, q);
		chk(16'(q), 16'h003c);
		chk(16'(busy_n - b0), 16'h0000);
		rd_chk(8'h90, 8'h00);
		$display("ram test done");
	endtask : t_ram
	task automatic flash_op(input logic [7:0] ctl, input logic [14:0] fa,
		input int len, input logic [7:0] wd);
		int b0;
		b0 = busy_n;
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, ctl, q);
		CORE.move(1'b1, 1'b0, 16'h0523, 8'ha5, q);
		chk(16'(flash_addr_o), 16'(fa));
		chk(16'(flash_wdata_o), 16'(wd));
		chk(16'(flash_erase_o), 16'(ctl[1]));
		wait_idle();
		chk(16'(busy_n - b0), 16'(len));
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, 8'h00, q);
		$display("flash operation test done");
	endtask : flash_op
	task automatic t_refuse;
		int e0, b0, h0;
		e0 = err_n;
		b0 = busy_n;
		h0 = hit_n;
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, 8'h01, q);
		mon_safe_i = 1'b0;
		CORE.move(1'b1, 1'b0, 16'h0100, 8'h11, q);
		mon_safe_i = 1'b1;
		CORE.move(1'b1, 1'b0, 16'h7e10, 8'h22, q);
		CORE.reg_io(1'b1, fxa_pkg::PSC_ADDR, 8'h00, q);
		chk(16'(err_n - e0), 16'h0002);
		chk(16'(busy_n - b0), 16'h0000);
		chk(16'(hit_n - h0), 16'h0001);
		$display("refusal test done");
	endtask : t_refuse
	task automatic t_slow;
		int s0;
		@(negedge mclk_i);
		slow_clock_i = 1'b1;
		s0 = st_n;
		CORE.fetch();
		repeat (3) @(negedge mclk_i);
		chk(16'(st_n - s0), 16'h0001);
		@(negedge mclk_i);
		os_period_i = 4'h0;
		os_period_wr_i = 1'b1;
		@(negedge mclk_i);
		os_period_wr_i = 1'b0;
		s0 = st_n;
		CORE.fetch();
		repeat (3) @(negedge mclk_i);
		chk(16'(st_n - s0), 16'h0000);
		slow_clock_i = 1'b0;
		$display("slow clock test done");
	endtask : t_slow
	task automatic t_strobe;
		int s0;
		for (int i = 1; i <= 2; i++) begin
			CORE.reg_io(1'b1, fxa_pkg::FRS_ADDR, i == 2 ? 8'h10 : 8'h00, q);
			s0 = st_n;
			CORE.fetch();
			repeat (3) @(negedge mclk_i);
			chk(16'(st_n - s0), 16'(i));
		end
		rd_chk(fxa_pkg::FRS_ADDR, 8'h10);
		$display("strobe test done");
	endtask : t_strobe
	initial begin
		repeat (16) @(negedge mclk_i);
		reset_i = 1'b0;
		t_regs();
		t_ram();
		flash_op(8'h01, 15'h0523, 5, 8'ha5);
		flash_op(8'h03, 15'h0400, 20, 8'h00);
		t_refuse();
		t_slow();
		t_strobe();
		close_out();
	end
endmodule : tb
